// File: src/wdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_top
  import wdc_pkg::*;
#(
  parameter int WD_PERIOD_CYC = WDC_WD_PERIOD_CYC,
  parameter int OC_LONG_CYC   = WDC_OC_LONG_CYC
)
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       sck_in,
  input  wire logic       cs_b_in,
  input  wire logic       mosi_in,
  input  wire logic       init_mode_in,
  input  wire logic       lp_mode_in,
  input  wire logic       wd_enable_in,
  input  wire logic       irq_pending_in,
  input  wire logic       irq_read_in,
  input  wire logic       over_current_in,
  input  wire logic       low_battery_in,
  input  wire logic [7:0] random_code_in,
  output logic [7:0]      setup_out,
  output logic            rst_pin_b_out,
  output logic            safe_b_out,
  output logic            wake_out,
  output logic            reg_on_out,
  output logic            refresh_ok_out
);
  logic [1:0] rs_q;
  logic       rst_b;
  logic [1:0] s1_q, s2_q, s3_q;
  logic [5:0] p1_q, p2_q;
  wdc_frame_t frame;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rs_q <= 2'b00;
    else
      rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_b = rs_q[1];

  // two-flop sync for every asynchronous pin except irq_pending_in and random_code_in
  always_ff @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= 2'b00;
      s2_q <= 2'b11;
      s3_q <= 2'b00;
      p1_q <= 6'h00;
      p2_q <= 6'h00;
    end
    else
    begin
      s1_q <= {s1_q[0], sck_in};
      s2_q <= {s2_q[0], cs_b_in};
      s3_q <= {s3_q[0], mosi_in};
      p1_q <= {init_mode_in, lp_mode_in, wd_enable_in, irq_read_in,
               over_current_in, low_battery_in};
      p2_q <= p1_q;
    end
  end

  wdc_spi_rx u_rx
  (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b),
    .sck_in    (s1_q[1]),
    .cs_b_in   (s2_q[1]),
    .mosi_in   (s3_q[1]),
    .frame_out (frame)
  );

  logic init_s, lp_s, wden_s, irqrd_s, oc_s, lowbat_s;
  assign {init_s, lp_s, wden_s, irqrd_s, oc_s, lowbat_s} = p2_q;

  wdc_setup_t  cfg_q, cfg_d;
  logic [15:0] per_q, per_d;
  logic [1:0]  pend_q, pend_d;
  logic [1:0]  part_q, part_d;
  logic [17:0] oc_q, oc_d;
  logic        wake_q, wake_d, rstp_q, rstp_d, safe_q, safe_d;
  logic        first_q, first_d, regon_q, regon_d, ok_q, ok_d;
  logic        hit, win_open, refresh_ok, bad_refresh, expire, deadline_miss;
  logic        oc_refresh, oc_short_done, oc_long_done, boundary, wd_trip;
  logic [1:0]  need;

  // frame decode and refresh legality
  always_comb
  begin
    need       = 2'd0;
    refresh_ok = 1'b0;
    hit        = frame.valid && frame.word[15:14] == WDC_CMD_REFRESH;
    win_open   = !cfg_q.window || (per_q >= 16'(WD_PERIOD_CYC / 2));
    unique case (cfg_q.scheme)
      WDC_SCH_SIMPLE: refresh_ok = hit;
      WDC_SCH_ONE:    refresh_ok = hit && frame.long16 &&
                                   frame.word[7:0] == ~random_code_in;
      WDC_SCH_TWO:    need = 2'd1;
      WDC_SCH_FOUR:   need = 2'd3;
    endcase
    if (cfg_q.scheme == WDC_SCH_TWO || cfg_q.scheme == WDC_SCH_FOUR)
      refresh_ok = hit && frame.long16 && part_q == need &&
                   frame.word[7:0] == (random_code_in ^ {6'h00, part_q});
  end

  // overcurrent timing in low-power supply-on mode
  always_comb
  begin
    oc_short_done = oc_q >= 18'(WDC_OC_SHORT_CYC);
    oc_long_done  = oc_q >= 18'(OC_LONG_CYC);
    oc_d          = (oc_s && lp_s) ? ((oc_q == '1) ? oc_q : 18'(oc_q + 18'd1)) : '0;
    // short pulse ending with watchdog and 11 counts as a refresh
    oc_refresh    = lp_s && wden_s && cfg_q.watch_sel && cfg_q.timer_sel && !oc_s &&
                    oc_q != '0 && !oc_long_done;
  end

  assign expire        = per_q == 16'(WD_PERIOD_CYC - 1);
  assign bad_refresh   = hit && !win_open && !(cfg_q.scheme == WDC_SCH_SIMPLE && 1'b0);
  // a period ends on an accepted refresh or on expiry; the count restarts either way
  assign boundary      = (refresh_ok && win_open) || oc_refresh || expire;
  // pending 1 covers the rest of the current period, 2 and 3 the two full ones
  assign deadline_miss = cfg_q.deadline_en && pend_q == 2'd3 && boundary;
  assign wd_trip       = wden_s && !init_s && (expire || bad_refresh || deadline_miss);

  // main state update
  always_comb
  begin
    cfg_d   = cfg_q;
    per_d   = 16'(per_q + 16'd1);
    pend_d  = pend_q;
    part_d  = part_q;
    wake_d  = 1'b0;
    rstp_d  = 1'b1;
    safe_d  = safe_q;
    first_d = first_q;
    ok_d    = 1'b0;
    regon_d = cfg_q.crank || !lowbat_s;
    if (frame.valid && frame.long16 && frame.word[15:14] == WDC_CMD_WRITE &&
        frame.word[11:8] == WDC_SETUP_ADDR && init_s)
      cfg_d = wdc_setup_t'(frame.word[7:0]);
    if (hit && (cfg_q.scheme == WDC_SCH_TWO || cfg_q.scheme == WDC_SCH_FOUR) && win_open)
      part_d = (part_q == need) ? 2'd0 : 2'(part_q + 2'd1);
    // period counter wraps even with the watchdog off, so enabling it keeps the phase sane
    if (boundary)
      per_d = '0;
    if ((refresh_ok && win_open) || oc_refresh)
    begin
      ok_d    = 1'b1;
      first_d = 1'b0;
    end
    if (boundary && pend_q != 2'd0 && pend_q != 2'd3)
      pend_d = 2'(pend_q + 2'd1);
    if (irq_pending_in && pend_q == 2'd0)
      pend_d = 2'd1;
    if (irqrd_s)
      pend_d = 2'd0;
    // missed period, bad window refresh or missed deadline: reset pulse
    if (wd_trip)
    begin
      rstp_d  = 1'b0;
      per_d   = '0;
      pend_d  = 2'd0;
      part_d  = 2'd0;
      first_d = 1'b1;
      if (!cfg_q.safe2 || first_q)
        safe_d = 1'b0;
    end
    if (lp_s && cfg_q.watch_sel && !cfg_q.timer_sel && oc_short_done)
      wake_d = 1'b1;
    if (lp_s && cfg_q.watch_sel && cfg_q.timer_sel && oc_long_done)
      wake_d = 1'b1;
    // monitor 00/01 leave wake low
    // held in reset for as long as the battery stays low without crank hold
    if (lowbat_s && !cfg_q.crank)
      rstp_d = 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_q   <= wdc_setup_t'(WDC_SETUP_RST);
      per_q   <= '0;
      pend_q  <= 2'd0;
      part_q  <= 2'd0;
      oc_q    <= '0;
      wake_q  <= 1'b0;
      rstp_q  <= 1'b1;
      safe_q  <= 1'b1;
      first_q <= 1'b0;
      regon_q <= 1'b1;
      ok_q    <= 1'b0;
    end
    else
    begin
      cfg_q   <= cfg_d;
      per_q   <= per_d;
      pend_q  <= pend_d;
      part_q  <= part_d;
      oc_q    <= oc_d;
      wake_q  <= wake_d;
      rstp_q  <= rstp_d;
      safe_q  <= safe_d;
      first_q <= first_d;
      regon_q <= regon_d;
      ok_q    <= ok_d;
    end
  end

  assign setup_out      = cfg_q;
  assign rst_pin_b_out  = rstp_q;
  assign safe_b_out     = safe_q;
  assign wake_out       = wake_q;
  assign reg_on_out     = regon_q;
  assign refresh_ok_out = ok_q;

  // checks
  a_write_init_only: assert property (@(posedge clk_in) disable iff (!rst_b)
    !init_s |=> $stable(cfg_q) || !$past(init_s) == 1'b0 || cfg_q == $past(cfg_q))
    else $error("setup changed outside init");
  a_safe_first_rst: assert property (@(posedge clk_in) disable iff (!rst_b)
    ($past(wd_trip) && !$past(cfg_q.safe2)) |-> !safe_b_out)
    else $error("safe not low with first reset");
  a_safe_second: assert property (@(posedge clk_in) disable iff (!rst_b)
    ($fell(safe_b_out) && $past(cfg_q.safe2)) |-> $past(first_q))
    else $error("safe fell before second reset");
  a_no_wake_ignore: assert property (@(posedge clk_in) disable iff (!rst_b)
    (!cfg_q.watch_sel && $stable(cfg_q)) |=> !wake_out)
    else $error("wake with monitor off");
  a_wake_short: assert property (@(posedge clk_in) disable iff (!rst_b)
    $rose(wake_out) |->
    $past(oc_q) >= ($past(cfg_q.timer_sel) ? 18'(OC_LONG_CYC) : 18'(WDC_OC_SHORT_CYC)))
    else $error("wake too early");
  a_window_closed: assert property (@(posedge clk_in) disable iff (!rst_b)
    (hit && cfg_q.window && per_q < 16'(WD_PERIOD_CYC / 2) && wden_s && !init_s)
    |=> !rst_pin_b_out)
    else $error("early refresh not punished");
  a_crank_hold: assert property (@(posedge clk_in) disable iff (!rst_b)
    (cfg_q.crank) |=> reg_on_out)
    else $error("regulator dropped with crank set");
  a_reg_off: assert property (@(posedge clk_in) disable iff (!rst_b)
    (!cfg_q.crank && lowbat_s) |=> !reg_on_out)
    else $error("regulator stayed on");
  c_refresh: cover property (@(posedge clk_in) refresh_ok_out);
  c_wake: cover property (@(posedge clk_in) wake_out);
  c_safe: cover property (@(posedge clk_in) !safe_b_out);
endmodule : wdc_top
`default_nettype wire

// File: src/wdc_pkg.sv
package wdc_pkg;

  // register placement and field layout
  localparam logic [3:0] WDC_SETUP_ADDR    = 4'h6;
  localparam int         WDC_B_DEADLINE    = 7;
  localparam int         WDC_B_WATCH       = 6;
  localparam int         WDC_B_TIMER       = 5;
  localparam int         WDC_B_SAFE2       = 4;
  localparam int         WDC_B_SCHEME_HI   = 3;
  localparam int         WDC_B_SCHEME_LO   = 2;
  localparam int         WDC_B_WINDOW      = 1;
  localparam int         WDC_B_CRANK       = 0;
  localparam logic [7:0] WDC_SETUP_RST     = 8'h42;

  // frame layout: 16 bits, msb first
  localparam int         WDC_FRAME_BITS    = 16;
  localparam logic [1:0] WDC_CMD_WRITE     = 2'b01;
  localparam logic [1:0] WDC_CMD_READ      = 2'b00;
  localparam logic [1:0] WDC_CMD_REFRESH   = 2'b10;

  // timing at 50 MHz
  localparam int         WDC_CLK_MHZ       = 50;
  localparam int         WDC_OC_SHORT_US   = 100;
  localparam int         WDC_OC_SHORT_CYC  = WDC_OC_SHORT_US * WDC_CLK_MHZ;
  localparam int         WDC_WD_PERIOD_CYC = 8192;
  localparam int         WDC_OC_LONG_CYC   = 150000;

  typedef enum logic [1:0] {WDC_SCH_SIMPLE, WDC_SCH_ONE, WDC_SCH_TWO, WDC_SCH_FOUR}
    wdc_scheme_t;

  typedef struct packed {
    logic        deadline_en;
    logic        watch_sel;
    logic        timer_sel;
    logic        safe2;
    wdc_scheme_t scheme;
    logic        window;
    logic        crank;
  } wdc_setup_t;

  typedef struct packed {
    logic        valid;
    logic        long16;
    logic [15:0] word;
  } wdc_frame_t;

endpackage : wdc_pkg

// File: src/wdc_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none
// spi frame receiver; pins already synchronised by the caller
module wdc_spi_rx
  import wdc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       sck_in,
  input  wire logic       cs_b_in,
  input  wire logic       mosi_in,
  output wdc_frame_t      frame_out
);
  logic        sck_q, sck_d;
  logic        cs_q, cs_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0]  cnt_q, cnt_d;
  wdc_frame_t  fr_q, fr_d;

  // shift on rising sck, close frame on cs release
  always_comb
  begin
    sck_d = sck_in;
    cs_d  = cs_b_in;
    sh_d  = sh_q;
    cnt_d = cnt_q;
    fr_d  = '0;
    if (!cs_b_in && sck_in && !sck_q)
    begin
      sh_d  = {sh_q[14:0], mosi_in};
      cnt_d = (cnt_q == 5'h1F) ? cnt_q : 5'(cnt_q + 5'h01);
    end
    if (cs_b_in && !cs_q)
    begin
      // 8 or 16 bits only; others are discarded
      fr_d.valid  = (cnt_q == 5'h08) || (cnt_q == 5'h10);
      fr_d.long16 = (cnt_q == 5'h10);
      fr_d.word   = (cnt_q == 5'h08) ? {sh_q[7:0], 8'h00} : sh_q;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
      sh_q  <= '0;
      cnt_q <= '0;
      fr_q  <= '0;
    end
    else
    begin
      sck_q <= sck_d;
      cs_q  <= cs_d;
      sh_q  <= sh_d;
      cnt_q <= cnt_d;
      fr_q  <= fr_d;
    end
  end

  assign frame_out = fr_q;
endmodule : wdc_spi_rx
`default_nettype wire

// File: sim/wdc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host spi master: mode 0, msb first, 160 ns bit time
module wdc_host
(
  input  wire logic clk_in,
  output logic      sck_out,
  output logic      cs_b_out,
  output logic      mosi_out
);
  initial
  begin
    sck_out  = 1'b0;
    cs_b_out = 1'b1;
    mosi_out = 1'b0;
  end
  // short frames use the upper byte; link clock stands still between frames
  task send(input logic [15:0] word, input logic short8);
    int nb;
    nb = short8 ? 8 : 16;
    // gap before the frame; the one-cycle tail after cs release makes the answer to this frame fall after the call returns
    repeat (8) @(negedge clk_in);
    cs_b_out = 1'b0;
    for (int i = 15; i > 15 - nb; i--)
    begin
      mosi_out = word[i];
      repeat (4) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sck_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    cs_b_out = 1'b1;
    // released data line flips so a stale bit never passes for a driven one
    mosi_out = ~mosi_out;
    @(negedge clk_in);
  endtask : send
endmodule : wdc_host
`default_nettype wire

// File: sim/wdc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_top_tb;
  import wdc_pkg::*;
  logic       clk_in, rst_b_in, init, lp, wd_en, oc, low_bat, irq;
  logic [7:0] rc, setup;
  logic       sck, cs_b, mosi, rst_pin_b, safe_b, wake, reg_on, ref_ok;
  int         error_cnt, cmp_count, np;
  logic       safe_at [4];

  wdc_top #(.WD_PERIOD_CYC(1024), .OC_LONG_CYC(200)) i_wdc_top (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .sck_in(sck), .cs_b_in(cs_b), .mosi_in(mosi),
    .init_mode_in(init), .lp_mode_in(lp), .wd_enable_in(wd_en), .irq_pending_in(irq),
    .irq_read_in(1'b0), .over_current_in(oc), .low_battery_in(low_bat),
    .random_code_in(rc), .setup_out(setup), .rst_pin_b_out(rst_pin_b),
    .safe_b_out(safe_b), .wake_out(wake), .reg_on_out(reg_on), .refresh_ok_out(ref_ok));
  wdc_host i_wdc_host (.clk_in(clk_in), .sck_out(sck), .cs_b_out(cs_b), .mosi_out(mosi));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // safe level captured in each of the first four cycles with the reset pin low
  always @(posedge clk_in)
  begin
    if (rst_pin_b === 1'b0 && np < 4)
    begin
      safe_at[np] = safe_b;
      np++;
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task reset_dut;
    @(negedge clk_in);
    rst_b_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (6) @(negedge clk_in);
    np = 0;
  endtask : reset_dut
  // observe wake (0) or refresh_ok (1) for lim cycles
  task watch(input int lim, input int sel, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (lim)
    begin
      @(negedge clk_in);
      if ((sel == 0 ? wake : ref_ok) === 1'b1)
        seen = 1'b1;
    end
    chk(seen, exp);
  endtask : watch
  task cfg(input logic [7:0] d);
    init = 1'b1;
    i_wdc_host.send({8'h46, d}, 1'b0);
    repeat (10) @(negedge clk_in);
    init = 1'b0;
  endtask : cfg
  task refresh(input logic [15:0] w, input logic s8, input logic exp);
    i_wdc_host.send(w, s8);
    watch(20, 1, exp);
  endtask : refresh

  initial
  begin
    rst_b_in = 1'b0;
    {init, lp, oc, low_bat, irq} = 5'h00;
    wd_en = 1'b1;
    rc = 8'h3c;
    error_cnt = 0;
    cmp_count = 0;
    np = 0;
    reset_dut();
    chk(setup, WDC_SETUP_RST);
    chk({rst_pin_b, safe_b, wake, reg_on, ref_ok}, 8'h1a);
    i_wdc_host.send(16'h46a5, 1'b0);
    repeat (10) @(negedge clk_in);
    chk(setup, WDC_SETUP_RST);
    cfg(8'h80);
    chk(setup, 8'h80);
    $display("setup access test done");
    // every refresh scheme, timeout mode, refreshes back to back
    for (int s = 0; s < 4; s++)
    begin
      cfg(8'h50 | 8'(s << 2));
      chk(setup, 8'h50 | 8'(s << 2));
      if (s == 0)
      begin
        refresh(16'h8000, 1'b1, 1'b1);
        refresh(16'h8000, 1'b0, 1'b1);
      end
      else if (s == 1)
      begin
        refresh({8'h80, rc}, 1'b0, 1'b0);
        refresh({8'h80, ~rc}, 1'b0, 1'b1);
      end
      else
        for (int k = 0; k < 2 * (s - 1); k++)
          refresh({8'h80, rc ^ 8'(k)}, 1'b0, k == 2 * s - 3);
    end
    $display("refresh scheme test done");
    // early refresh in window mode: safe at first or second pulse
    reset_dut();
    refresh(16'h8000, 1'b0, 1'b0);
    chk(8'(np), 8'h01);
    chk(safe_at[0], 1'b0);
    reset_dut();
    cfg(8'h52);
    refresh(16'h8000, 1'b0, 1'b0);
    refresh(16'h8000, 1'b0, 1'b0);
    chk(8'(np), 8'h02);
    chk({safe_at[0], safe_at[1]}, 8'h02);
    $display("window and safe test done");
    // interrupt read deadline: rest of period plus two full periods
    reset_dut();
    cfg(8'h80);
    irq = 1'b1;
    @(negedge clk_in);
    irq = 1'b0;
    refresh(16'h8000, 1'b0, 1'b1);
    refresh(16'h8000, 1'b0, 1'b1);
    chk(8'(np), 8'h00);
    refresh(16'h8000, 1'b0, 1'b1);
    chk(8'(np), 8'h01);
    $display("deadline test done");
    reset_dut();
    cfg(8'h43);
    low_bat = 1'b1;
    repeat (30) @(negedge clk_in);
    chk(reg_on, 1'b1);
    cfg(8'h42);
    repeat (30) @(negedge clk_in);
    chk(reg_on, 1'b0);
    low_bat = 1'b0;
    $display("crank test done");
    // current monitor: no effect, 100 us wake, selected time wake, short refresh
    reset_dut();
    cfg(8'h00);
    wd_en = 1'b0;
    {lp, oc} = 2'b11;
    watch(6000, 0, 1'b0);
    {lp, oc} = 2'b00;
    cfg(8'h40);
    {lp, oc} = 2'b11;
    watch(4800, 0, 1'b0);
    watch(600, 0, 1'b1);
    {lp, oc} = 2'b00;
    cfg(8'h60);
    {lp, oc} = 2'b11;
    watch(150, 0, 1'b0);
    watch(100, 0, 1'b1);
    {lp, oc} = 2'b00;
    wd_en = 1'b1;
    lp = 1'b1;
    repeat (10) @(negedge clk_in);
    oc = 1'b1;
    watch(100, 1, 1'b0);
    oc = 1'b0;
    watch(20, 1, 1'b1);
    oc = 1'b1;
    watch(300, 0, 1'b1);
    $display("current monitor test done");
    stop_test();
  end
endmodule : wdc_top_tb
`default_nettype wire
